// >>> verilog/bus_matrix_pkg.sv
// constants for the system bus matrix and its address decoding
package bus_matrix_pkg;
   localparam int NUM_MASTERS = 6;
   localparam int NUM_SLAVES  = 6;
   localparam int ADDR_W      = 32;
   localparam int DATA_W      = 32;
   // master numbering
   localparam int M_CPU_DATA   = 0;
   localparam int M_CPU_INSTR  = 1;
   localparam int M_CPU_DEBUG  = 2;
   localparam int M_PERIPH_DMA = 3;
   localparam int M_ETH_DMA    = 4;
   localparam int M_USB_DMA    = 5;
   // slave numbering
   localparam logic [2:0] S_FLASH   = 3'h0;
   localparam logic [2:0] S_BRIDGE0 = 3'h1;
   localparam logic [2:0] S_BRIDGE1 = 3'h2;
   localparam logic [2:0] S_SRAM    = 3'h3;
   localparam logic [2:0] S_USB_RAM = 3'h4;
   localparam logic [2:0] S_EXT_BUS = 3'h5;
   localparam logic [2:0] S_NONE    = 3'h7;
   // region bases
   localparam logic [31:0] SRAM_BASE    = 32'h0000_0000;
   localparam logic [31:0] FLASH_BASE   = 32'h8000_0000;
   localparam logic [31:0] EXT_CS0_BASE = 32'hC000_0000;
   localparam logic [31:0] EXT_CS2_BASE = 32'hC800_0000;
   localparam logic [31:0] EXT_CS3_BASE = 32'hCC00_0000;
   localparam logic [31:0] EXT_DYN_BASE = 32'hD000_0000;
   localparam logic [31:0] USB_BASE     = 32'hE000_0000;
   localparam logic [31:0] BRIDGE0_BASE = 32'hFFFE_0000;
   localparam logic [31:0] BRIDGE1_BASE = 32'hFFFF_0000;
   // region sizes in bytes, default memory sizes in Kbytes
   localparam logic [31:0] SIZE_64K  = 32'h0001_0000;
   localparam logic [31:0] SIZE_16M  = 32'h0100_0000;
   localparam logic [31:0] SIZE_128M = 32'h0800_0000;
   localparam int SRAM_KB_DEF  = 64;
   localparam int FLASH_KB_DEF = 512;
   // response codes
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_ERROR = 2'h1;
endpackage

// >>> verilog/system_bus_matrix_decoder.sv
// six by six system bus matrix with per-master decoders and per-slave arbiters
// Notes on behaviour
// - fixed 32-bit address map, identical at all times, never remapped.
// - addresses from 0x0000_0000 go to SRAM, 64 or 32 Kbyte.
// - addresses from 0x8000_0000 go to flash, 512, 256 or 128 Kbyte.
// - external static selects 0, 2, 3 at 0xC000_0000, 0xC800_0000, 0xCC00_0000.
// - 128 Mbyte window at 0xD000_0000 for static cs1 / dynamic cs0.
// - 64 Kbyte window at 0xE000_0000 goes to USB slave region.
// - 64 Kbyte window at 0xFFFE_0000 goes to bridge 0.
// - 64 Kbyte window at 0xFFFF_0000 goes to bridge 1.
// - unmapped access completes with an error to the requesting master.
// - each master has its own bus and its own decoder.
// - each slave has its own arbiter.
// - masters 0..5: cpu data, instr, debug, periph dma, eth dma, usb dma.
// - slaves 0..5: flash, bridge0, bridge1, sram, usb ram, external bus.
// - SRAM accesses complete in a single cycle.
`timescale 1ns/1ps
`default_nettype none
module system_bus_matrix_decoder
   import bus_matrix_pkg::*;
#(
   parameter int SRAM_KB     = SRAM_KB_DEF,
   parameter int FLASH_KB    = FLASH_KB_DEF,
   parameter bit HAS_EXT_BUS = 1'b1
)(
   input  wire logic                      MCLK,
   input  wire logic                      RST_N,
   input  wire logic                      CE,
   input  wire logic [NUM_MASTERS-1:0]    M_REQ,
   input  wire logic [NUM_MASTERS*32-1:0] M_ADDR,
   output logic      [NUM_MASTERS-1:0]    M_DONE,
   output logic      [NUM_MASTERS-1:0]    M_ERR,
   output logic      [NUM_SLAVES-1:0]     S_SEL,
   output logic      [NUM_SLAVES*32-1:0]  S_ADDR,
   output logic      [NUM_SLAVES*3-1:0]   S_MASTER,
   input  wire logic [NUM_SLAVES-1:0]     S_DONE
);
   // refuse sizes the decoder cannot serve
   if (!(SRAM_KB == 64 || SRAM_KB == 32))
   begin : g_bad_sram
      $error("SRAM_KB must be 32 or 64");
   end
   if (!(FLASH_KB == 512 || FLASH_KB == 256 || FLASH_KB == 128))
   begin : g_bad_flash
      $error("FLASH_KB must be 128, 256 or 512");
   end

   localparam logic [31:0] SRAM_SIZE  = 32'(SRAM_KB * 1024);
   localparam logic [31:0] FLASH_SIZE = 32'(FLASH_KB * 1024);

   logic rst_s1_r, rst_s2_r;
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire rst_n = rst_s2_r;

   // fixed map decode, shared by every master decoder
   function automatic logic [2:0] decode(input logic [31:0] a);
      logic [2:0] s;
      s = S_NONE;
      if (a - SRAM_BASE < SRAM_SIZE) s = S_SRAM;
      else if (a - FLASH_BASE < FLASH_SIZE) s = S_FLASH;
      else if (HAS_EXT_BUS && (a - EXT_CS0_BASE < SIZE_16M || a - EXT_CS2_BASE < SIZE_16M
               || a - EXT_CS3_BASE < SIZE_16M)) s = S_EXT_BUS;
      else if (HAS_EXT_BUS && a - EXT_DYN_BASE < SIZE_128M) s = S_EXT_BUS;
      else if (a - USB_BASE < SIZE_64K) s = S_USB_RAM;
      else if (a - BRIDGE0_BASE < SIZE_64K) s = S_BRIDGE0;
      else if (a - BRIDGE1_BASE < SIZE_64K) s = S_BRIDGE1;
      return s;
   endfunction

   logic [2:0]             m_tgt [NUM_MASTERS];
   logic [NUM_MASTERS-1:0] m_unmapped;
   logic [NUM_MASTERS-1:0] err_r;
   logic [NUM_MASTERS-1:0] done_r;
   logic [NUM_SLAVES-1:0]  busy_r;
   logic [2:0]             owner_r [NUM_SLAVES];
   logic [2:0]             last_r  [NUM_SLAVES];
   logic [NUM_SLAVES-1:0]  sel_r;
   logic [31:0]            saddr_r [NUM_SLAVES];
   logic [NUM_MASTERS-1:0] m_busy_r;
   logic [NUM_SLAVES-1:0]  s_fin;
   logic [NUM_SLAVES-1:0]  s_any;
   logic [2:0]             s_pick  [NUM_SLAVES];
   logic [NUM_MASTERS-1:0] m_fin;
   logic [NUM_MASTERS-1:0] m_grant;

   genvar gm, gs;
   generate
      for (gm = 0; gm < NUM_MASTERS; gm++)
      begin : g_dec
         assign m_tgt[gm]      = decode(M_ADDR[gm*32 +: 32]);
         assign m_unmapped[gm] = M_REQ[gm] && m_tgt[gm] == S_NONE && !m_busy_r[gm];
      end
   endgenerate

   // unmapped requests answer error in one cycle
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n) err_r <= '0;
      else if (CE) err_r <= m_unmapped & ~err_r;
   end

   generate
      for (gs = 0; gs < NUM_SLAVES; gs++)
      begin : g_arb
         logic [NUM_MASTERS-1:0] want;
         logic [2:0]             pick;
         logic                   any;
         for (gm = 0; gm < NUM_MASTERS; gm++)
         begin : g_w
            assign want[gm] = M_REQ[gm] && m_tgt[gm] == 3'(gs) && !m_busy_r[gm];
         end
         // round robin starting after the last granted master
         always_comb
         begin
            logic [2:0] idx;
            idx  = 3'h0;
            pick = 3'h0;
            any  = 1'b0;
            for (int k = 1; k <= NUM_MASTERS; k++)
            begin
               idx = 3'((int'(last_r[gs]) + k) % NUM_MASTERS);
               if (!any && want[idx])
               begin
                  any  = 1'b1;
                  pick = idx;
               end
            end
         end
         always_ff @(posedge MCLK or negedge rst_n)
         begin
            if (!rst_n)
            begin
               busy_r[gs]  <= 1'b0;
               sel_r[gs]   <= 1'b0;
               owner_r[gs] <= 3'h0;
               last_r[gs]  <= 3'(NUM_MASTERS - 1);
               saddr_r[gs] <= 32'h0000_0000;
            end
            else if (CE)
            begin
               if (s_fin[gs])
               begin
                  busy_r[gs] <= 1'b0;
                  sel_r[gs]  <= 1'b0;
               end
               else if (!busy_r[gs] && any)
               begin
                  busy_r[gs]  <= 1'b1;
                  sel_r[gs]   <= 1'b1;
                  owner_r[gs] <= pick;
                  last_r[gs]  <= pick;
                  saddr_r[gs] <= M_ADDR[pick*32 +: 32];
               end
            end
         end
         assign S_ADDR[gs*32 +: 32] = saddr_r[gs];
         assign S_MASTER[gs*3 +: 3] = owner_r[gs];
         assign s_fin[gs]  = busy_r[gs] && (S_DONE[gs] || 3'(gs) == S_SRAM);
         assign s_any[gs]  = any;
         assign s_pick[gs] = pick;
      end
   endgenerate

   // per-master view of slave completions and new grants
   always_comb
   begin
      m_fin   = '0;
      m_grant = '0;
      for (int s = 0; s < NUM_SLAVES; s++)
      begin
         if (s_fin[s])
            m_fin[owner_r[s]] = 1'b1;
         if (!busy_r[s] && s_any[s])
            m_grant[s_pick[s]] = 1'b1;
      end
   end

   // master done pulses and per-master busy bookkeeping
   // busy also clears after an error pulse, so the master may ask again
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_r   <= '0;
         m_busy_r <= '0;
      end
      else if (CE)
      begin
         done_r   <= m_fin | m_unmapped;
         m_busy_r <= (m_busy_r & ~m_fin & ~done_r) | m_grant | m_unmapped;
      end
   end

   assign M_DONE = done_r;
   assign M_ERR  = err_r;
   assign S_SEL  = sel_r;

   a_unmapped_err: assert property (@(posedge MCLK) disable iff (!rst_n)
      CE && m_unmapped[0] |=> M_ERR[0] && M_DONE[0])
      else $error("unmapped access without error");
   a_sram_single: assert property (@(posedge MCLK) disable iff (!rst_n)
      CE && S_SEL[S_SRAM] |=> !S_SEL[S_SRAM] || !CE)
      else $error("sram access longer than one cycle");
   a_sram_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_REQ[0] && M_ADDR[31:0] == SRAM_BASE |-> m_tgt[0] == S_SRAM)
      else $error("sram base misrouted");
   a_flash_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_ADDR[31:0] == FLASH_BASE |-> m_tgt[0] == S_FLASH)
      else $error("flash base misrouted");
   a_ext_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_ADDR[31:0] == EXT_CS2_BASE |-> m_tgt[0] == (HAS_EXT_BUS ? S_EXT_BUS : S_NONE))
      else $error("external select misrouted");
   a_dyn_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_ADDR[31:0] == EXT_DYN_BASE |-> m_tgt[0] == (HAS_EXT_BUS ? S_EXT_BUS : S_NONE))
      else $error("dynamic window misrouted");
   a_usb_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_ADDR[31:0] == USB_BASE |-> m_tgt[0] == S_USB_RAM)
      else $error("usb window misrouted");
   a_bridge_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_ADDR[31:0] == BRIDGE1_BASE |-> m_tgt[0] == S_BRIDGE1)
      else $error("bridge window misrouted");
   a_bridge0_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      M_ADDR[31:0] == BRIDGE0_BASE |-> m_tgt[0] == S_BRIDGE0)
      else $error("first bridge window misrouted");
   a_grant_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
      S_SEL[S_FLASH] && !S_DONE[S_FLASH] |=> S_SEL[S_FLASH] && $stable(S_MASTER[2:0]))
      else $error("flash grant dropped early");
endmodule
`default_nettype wire

// >>> dv/slave_model.sv
// far-side slave responders with a shared wait count
`timescale 1ns/1ps
`default_nettype none
module slave_model
   import bus_matrix_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic [NUM_SLAVES-1:0] sel,
   input  wire logic [3:0]            wait_n,
   output logic      [NUM_SLAVES-1:0] done
);
   logic [3:0] cnt_r [NUM_SLAVES];
   logic       tgl_r = 1'b0;
   always_ff @(posedge clk)
   begin
      tgl_r <= ~tgl_r;
      for (int s = 0; s < NUM_SLAVES; s++)
         cnt_r[s] <= sel[s] ? cnt_r[s] + 4'h1 : 4'h0;
   end
   // unselected slaves show a changing level
   always_comb
      for (int s = 0; s < NUM_SLAVES; s++)
         done[s] = sel[s] ? (cnt_r[s] >= wait_n) : tgl_r;
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the system bus matrix
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bus_matrix_pkg::*;
   logic                      MCLK = 1'b0;
   logic                      RST_N = 1'b0;
   logic [NUM_MASTERS-1:0]    M_REQ = '0;
   logic [NUM_MASTERS*32-1:0] M_ADDR = '0;
   logic [NUM_MASTERS-1:0]    M_DONE, M_ERR;
   logic [NUM_SLAVES-1:0]     S_SEL, S_DONE;
   logic [NUM_SLAVES*32-1:0]  S_ADDR;
   logic [NUM_SLAVES*3-1:0]   S_MASTER;
   logic                      CE = 1'b1;
   logic [3:0]                wait_n = 4'h0;
   logic [31:0]               cor [22] = '{32'h0, 32'hFFFC, 32'h1_0000,
      32'h8000_0000, 32'h8007_FFFC, 32'h8008_0000, 32'hC000_0000, 32'hC0FF_FFFC,
      32'hC100_0000, 32'hC800_0000, 32'hCC00_0000, 32'hCCFF_FFFF, 32'hD000_0000,
      32'hD7FF_FFFF, 32'hD800_0000, 32'hE000_0000, 32'hE000_FFFF, 32'hE001_0000,
      32'hFFFD_FFFF, 32'hFFFE_0000, 32'hFFFF_0000, 32'hFFFF_FFFF};
   int errors = 0;
   int n_tests = 0;
   int seed = 18592;
   always #5 MCLK = ~MCLK;
   system_bus_matrix_decoder #(.SRAM_KB(SRAM_KB_DEF), .FLASH_KB(FLASH_KB_DEF),
      .HAS_EXT_BUS(1'b1)) dut_u (.MCLK(MCLK), .RST_N(RST_N), .CE(CE),
      .M_REQ(M_REQ), .M_ADDR(M_ADDR), .M_DONE(M_DONE), .M_ERR(M_ERR), .S_SEL(S_SEL),
      .S_ADDR(S_ADDR), .S_MASTER(S_MASTER), .S_DONE(S_DONE));
   slave_model far_u (.clk(MCLK), .sel(S_SEL), .wait_n(wait_n), .done(S_DONE));
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [2:0] exp_slv(logic [31:0] a);
      if (a < SRAM_KB_DEF * 1024) return S_SRAM;
      if (a >= FLASH_BASE && a - FLASH_BASE < FLASH_KB_DEF * 1024) return S_FLASH;
      if (a[31:24] inside {8'hC0, 8'hC8, 8'hCC}) return S_EXT_BUS;
      if (a[31:27] == 5'h1A) return S_EXT_BUS;
      if (a[31:16] == 16'hE000) return S_USB_RAM;
      if (a[31:16] == 16'hFFFE) return S_BRIDGE0;
      if (a[31:16] == 16'hFFFF) return S_BRIDGE1;
      return S_NONE;
   endfunction
   // one transfer of master m; timed checks the fixed latencies
   task automatic access(int m, logic [31:0] a, bit timed);
      logic [2:0] ex;
      logic [2:0] seen;
      int n;
      ex = exp_slv(a);
      seen = S_NONE;
      M_ADDR[32*m +: 32] = a;
      M_REQ[m] = 1'b1;
      n = 0;
      do
      begin
         @(posedge MCLK);
         #1;
         n++;
         for (int s = 0; s < NUM_SLAVES; s++)
            if (S_SEL[s] === 1'b1 && S_MASTER[3*s +: 3] === m[2:0])
            begin
               seen = s[2:0];
               check("slave addr", S_ADDR[32*s +: 32], a);
            end
      end while (M_DONE[m] !== 1'b1 && n < 60);
      M_REQ[m] = 1'b0;
      if (n >= 60)
      begin
         errors++;
         test_done;
      end
      check("routed slave", {29'h0, seen}, {29'h0, ex});
      check("error flag", {31'h0, M_ERR[m]}, {31'h0, ex == S_NONE});
      if (timed && ex == S_SRAM) check("sram cycles", n, 2);
      if (timed && ex == S_NONE) check("error cycles", n, 1);
      @(posedge MCLK);
      #1;
   endtask
   initial
   begin
      repeat (12) @(posedge MCLK);
      #1 RST_N = 1'b1;
      repeat (3) @(posedge MCLK);
      #1;
      check("idle select", {26'h0, S_SEL}, 32'h0);
      for (int i = 0; i < 22 * NUM_MASTERS; i++)
         access(i % NUM_MASTERS, cor[i % 22], 1'b1);
      for (int i = 0; i < 150; i++)
      begin
         wait_n = 4'($random(seed));
         access(i % NUM_MASTERS, cor[$unsigned($random(seed)) % 22]
            + 32'($random(seed) & 32'hFFF), 1'b1);
      end
      wait_n = 4'h3;
      for (int k = 0; k < 4; k++)
         fork
            access(M_PERIPH_DMA, 32'h100, 1'b0);
            access(M_ETH_DMA, 32'hFFFE_0010, 1'b0);
            access(M_USB_DMA, 32'hFFFE_0020, 1'b0);
            access(M_CPU_DATA, 32'h0000_0040, 1'b0);
         join
      // clock enable low in mid transfer freezes grant and owner
      fork
         access(M_CPU_INSTR, 32'h8000_0100, 1'b0);
         begin
            @(posedge MCLK);
            #1 CE = 1'b0;
            repeat (3) @(posedge MCLK);
            #1;
            check("frozen select", {26'h0, S_SEL}, 32'h1);
            check("frozen owner", {29'h0, S_MASTER[2:0]}, 32'(M_CPU_INSTR));
            check("frozen done", {26'h0, M_DONE}, 32'h0);
            CE = 1'b1;
         end
      join
      test_done;
   end
endmodule
`default_nettype wire
